//--- core/ccrd_top.sv
// Clock ratio divider: control register, fast RC postscaler and the
// CPU-to-peripheral ratio divider.
// Assumes all tick and interrupt inputs come from logic on clock, so
// none is synchronised; the register port is a one-cycle strobe port.
//
// Operation
// RQ1 - With recover set an interrupt clears ratio enable, else leaves it.
// RQ2 - Enabled, the CPU tick is the periph tick over 2**ratio; else 1:1.
// RQ3 - At selection 111 the postscaler divides 8 MHz by 2**code, 111 by 256.
// RQ4 - At selection 110 the same codes divide the 500 kHz tick.
// RQ5 - Reset loads recover 0, ratio 011, enable 0, postscale 001; all R/W.
// RQ6 - Control bits 7 to 0 read zero and ignore writes.
// RQ7 - New divider settings apply only at a divider boundary, no short pulse.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module ccrd_top import ccrd_pkg::*; #(
  parameter int AW = CCRD_AW
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata,
  input  wire logic [2:0]    current_osc_select,
  input  wire logic          fast_rc_tick,
  input  wire logic          slow_rc_tick,
  input  wire logic          osc_tick,
  input  wire logic          irq_in,
  output logic               periph_tick,
  output logic               cpu_tick,
  output logic               ratio_active
);
  typedef struct packed {
    logic        recover_on_irq;
    logic [2:0]  ratio_sel;
    logic        ratio_apply_en;
    logic [2:0]  fast_rc_postscale;
    logic [15:0] rdata;
    logic        active;
  } ccrd_st_t;

  ccrd_st_t    s;
  ccrd_st_t    next_s;
  logic        hit;
  logic        src_tick;
  logic [7:0]  post_term;
  logic [6:0]  ratio_term;
  logic [15:0] ctl_word;

  assign hit = (reg_addr == AW'(CCRD_ADDR_CTL));

  always_comb begin
    ctl_word                 = 16'h0000; // RQ6
    ctl_word[CCRD_RECOVER_BIT] = s.recover_on_irq;
    ctl_word[CCRD_RATIO_LSB +: 3] = s.ratio_sel;
    ctl_word[CCRD_EN_BIT]    = s.ratio_apply_en;
    ctl_word[CCRD_POST_LSB +: 3]  = s.fast_rc_postscale;
  end

  // Postscaler source and divide table per oscillator selection
  always_comb begin
    src_tick  = osc_tick;
    post_term = 8'h00;
    if (current_osc_select == CCRD_OSC_FAST) begin
      src_tick  = fast_rc_tick; // RQ3
      post_term = ccrd_post_term(s.fast_rc_postscale); // RQ3
    end else if (current_osc_select == CCRD_OSC_SLOW) begin
      src_tick  = slow_rc_tick; // RQ4
      post_term = ccrd_post_term(s.fast_rc_postscale); // RQ4
    end
  end

  // Ratio forced to 1:1 unless enabled
  assign ratio_term = s.ratio_apply_en ?
                      ccrd_ratio_term(s.ratio_sel) : 7'h00; // RQ2

  always_comb begin
    next_s       = s;
    next_s.rdata = 16'h0000;
    if (reg_rd && hit) begin
      next_s.rdata = ctl_word;
    end
    if (reg_wr && hit) begin
      // Low byte has no storage, so writes there vanish
      next_s.recover_on_irq    = reg_wdata[CCRD_RECOVER_BIT];
      next_s.ratio_sel         = reg_wdata[CCRD_RATIO_LSB +: 3];
      next_s.ratio_apply_en    = reg_wdata[CCRD_EN_BIT];
      next_s.fast_rc_postscale = reg_wdata[CCRD_POST_LSB +: 3];
    end
    // Hardware clear beats a same-cycle software set
    if (irq_in && s.recover_on_irq) begin
      next_s.ratio_apply_en = 1'b0; // RQ1
    end
    next_s.active = next_s.ratio_apply_en && (next_s.ratio_sel != 3'h0);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '{recover_on_irq:    CCRD_RECOVER_RST,
             ratio_sel:         CCRD_RATIO_RST,
             ratio_apply_en:    CCRD_EN_RST,
             fast_rc_postscale: CCRD_POST_RST,
             rdata:             16'h0000,
             active:            1'b0}; // RQ5
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  ccrd_div #(
    .W     (8),
    .T_RST (CCRD_POST_TRST)
  ) u_post (
    .clock    (clock),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .in_tick  (src_tick),
    .term_in  (post_term),
    .out_tick (periph_tick)
  );

  ccrd_div #(
    .W     (7),
    .T_RST (CCRD_RATIO_TRST)
  ) u_ratio (
    .clock    (clock),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .in_tick  (periph_tick),
    .term_in  (ratio_term),
    .out_tick (cpu_tick)
  );

  assign reg_rdata    = s.rdata;
  assign ratio_active = s.active;

  // Helper: high from the second enabled cycle after reset
  logic seen;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seen <= 1'b0;
    end else if (clk_en) begin
      seen <= 1'b1;
    end
  end

  sequence s_irq_recover;
    clk_en && irq_in && s.recover_on_irq;
  endsequence

  property p_irq_clears;
    @(posedge clock) disable iff (!resetn)
      s_irq_recover |=> !s.ratio_apply_en;
  endproperty
  a_irq_clears: assert property (p_irq_clears) // RQ1
    else $error("interrupt did not clear ratio enable");

  property p_irq_ignored;
    @(posedge clock) disable iff (!resetn)
      (clk_en && irq_in && !s.recover_on_irq && !(reg_wr && hit))
        |=> $stable(s.ratio_apply_en);
  endproperty
  a_irq_ignored: assert property (p_irq_ignored) // RQ1
    else $error("interrupt changed ratio enable with recover clear");

  property p_ratio_forced;
    @(posedge clock) disable iff (!resetn)
      (!s.ratio_apply_en && clk_en && periph_tick
        && u_ratio.s.term == 7'h00) |=> cpu_tick;
  endproperty
  a_ratio_forced: assert property (p_ratio_forced) // RQ2
    else $error("ratio not 1:1 while disabled");

  property p_ratio_max;
    @(posedge clock) disable iff (!resetn)
      (s.ratio_apply_en && s.ratio_sel == 3'h7) |-> ratio_term == 7'h7F;
  endproperty
  a_ratio_max: assert property (p_ratio_max) // RQ2
    else $error("ratio 111 is not 1:128");

  property p_fast_table;
    @(posedge clock) disable iff (!resetn)
      (current_osc_select == CCRD_OSC_FAST)
        |-> src_tick == fast_rc_tick
            && (s.fast_rc_postscale != 3'h0 || post_term == 8'h00)
            && (s.fast_rc_postscale != 3'h1 || post_term == 8'h01)
            && (s.fast_rc_postscale != 3'h6 || post_term == 8'h3F)
            && (s.fast_rc_postscale != 3'h7 || post_term == 8'hFF);
  endproperty
  a_fast_table: assert property (p_fast_table) // RQ3
    else $error("fast postscaler divisor wrong");

  property p_slow_source;
    @(posedge clock) disable iff (!resetn)
      (current_osc_select == CCRD_OSC_SLOW)
        |-> src_tick == slow_rc_tick
            && (s.fast_rc_postscale != 3'h0 || post_term == 8'h00)
            && (s.fast_rc_postscale != 3'h1 || post_term == 8'h01)
            && (s.fast_rc_postscale != 3'h7 || post_term == 8'hFF);
  endproperty
  a_slow_source: assert property (p_slow_source) // RQ4
    else $error("slow oscillator postscaler wrong");

  property p_reset_values;
    @(posedge clock) disable iff (!resetn)
      !seen |-> ctl_word == 16'h3100;
  endproperty
  a_reset_values: assert property (p_reset_values) // RQ5
    else $error("control register not at reset value");

  sequence s_read;
    clk_en && reg_rd && hit;
  endsequence

  property p_low_byte_zero;
    @(posedge clock) disable iff (!resetn)
      s_read |=> reg_rdata[7:0] == 8'h00
                 && reg_rdata[15:8] == $past(ctl_word[15:8]);
  endproperty
  a_low_byte_zero: assert property (p_low_byte_zero) // RQ6
    else $error("read data wrong or low byte not zero");
endmodule : ccrd_top

//--- core/ccrd_pkg.sv
// Constants and helpers for the clock ratio divider.
// Assumes one system clock; all ticks are single-cycle enables on it.
package ccrd_pkg;
  localparam int          CCRD_AW          = 4;
  localparam logic [3:0]  CCRD_ADDR_CTL    = 4'h0;
  // Field positions of the control register
  localparam int          CCRD_RECOVER_BIT = 15;
  localparam int          CCRD_RATIO_LSB   = 12;
  localparam int          CCRD_EN_BIT      = 11;
  localparam int          CCRD_POST_LSB    = 8;
  // Power-on values
  localparam logic        CCRD_RECOVER_RST = 1'b0;
  localparam logic [2:0]  CCRD_RATIO_RST   = 3'h3;
  localparam logic        CCRD_EN_RST      = 1'b0;
  localparam logic [2:0]  CCRD_POST_RST    = 3'h1;
  // Oscillator selections that use the postscaler, then divider terms and reset terms
  localparam logic [2:0]  CCRD_OSC_FAST    = 3'h7;
  localparam logic [2:0]  CCRD_OSC_SLOW    = 3'h6;
  localparam logic [2:0]  CCRD_POST_MAX    = 3'h7;
  localparam logic [7:0]  CCRD_TERM_256    = 8'hFF;
  localparam logic [7:0]  CCRD_POST_TRST   = 8'h01;
  localparam logic [6:0]  CCRD_RATIO_TRST  = 7'h00;

  // Terminal count of the postscaler: divide by 2**code, code 7 by 256
  function automatic logic [7:0] ccrd_post_term(input logic [2:0] code);
    logic [7:0] t;
    t = 8'h00;
    if (code == CCRD_POST_MAX) begin
      t = CCRD_TERM_256;
    end else begin
      t = 8'((9'h001 << code) - 9'h001);
    end
    return t;
  endfunction : ccrd_post_term

  // Terminal count of the ratio divider: divide by 2**field
  function automatic logic [6:0] ccrd_ratio_term(input logic [2:0] f);
    logic [6:0] t;
    t = 7'(( 8'h01 << f) - 8'h01);
    return t;
  endfunction : ccrd_ratio_term
endpackage : ccrd_pkg

//--- core/ccrd_div.sv
// Tick divider: one output pulse per term+1 input ticks.
// Assumes in_tick is a one-cycle enable on clock; term_in may change
// at any time and is only taken at a divider boundary.
`timescale 1ns/10ps
module ccrd_div import ccrd_pkg::*; #(
  parameter int            W     = 8,
  parameter logic [W-1:0]  T_RST = '0
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  input  wire logic          in_tick,
  input  wire logic [W-1:0]  term_in,
  output logic               out_tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] term;
    logic         out;
  } ccrd_div_st_t;

  ccrd_div_st_t s;
  ccrd_div_st_t next_s;

  always_comb begin
    next_s     = s;
    next_s.out = 1'b0;
    if (in_tick) begin
      if (s.cnt >= s.term) begin
        // New setting taken only here, so no pulse is cut short
        next_s.cnt  = '0; // RQ7
        next_s.term = term_in; // RQ7
        next_s.out  = 1'b1;
      end else begin
        next_s.cnt = W'(s.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '{cnt: '0, term: T_RST, out: 1'b0};
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign out_tick = s.out;

  property p_term_at_boundary;
    @(posedge clock) disable iff (!resetn)
      !$stable(s.term) |-> s.out && $past(s.cnt) >= $past(s.term);
  endproperty
  a_term_at_boundary: assert property (p_term_at_boundary) // RQ7
    else $error("divider setting changed off a boundary");

  property p_no_short_pulse;
    @(posedge clock) disable iff (!resetn)
      (s.out && clk_en) ##1 (s.cnt != '0) |-> !s.out;
  endproperty
  a_no_short_pulse: assert property (p_no_short_pulse) // RQ7
    else $error("divider pulse before count reached term");
endmodule : ccrd_div

//--- verification/ccrd_top_test.sv
// Self-checking bench for the clock ratio divider top level.
// Assumes one 50 MHz clock; inputs change by NBA at rising edges and
// outputs are sampled at falling edges.
`timescale 1ns/10ps
module ccrd_top_test;
  import ccrd_pkg::*;
  logic        clock;
  logic        resetn;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [2:0]  current_osc_select;
  logic        fast_rc_tick;
  logic        slow_rc_tick;
  logic        osc_tick;
  logic        irq_in;
  logic        periph_tick;
  logic        cpu_tick;
  logic        ratio_active;
  int          fails;
  int          tests_run;
  int          seed;
  int          per;
  logic [15:0] word;
  logic [15:0] got;

  ccrd_top u_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .current_osc_select(current_osc_select), .fast_rc_tick(fast_rc_tick),
    .slow_rc_tick(slow_rc_tick), .osc_tick(osc_tick), .irq_in(irq_in),
    .periph_tick(periph_tick), .cpu_tick(cpu_tick),
    .ratio_active(ratio_active));

  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd

  // Period between the 2nd and 3rd pulse, so a pending setting has landed
  task automatic measure(input bit use_cpu, output int p);
    int n;
    int last;
    n = 0;
    last = 0;
    for (int c = 0; c < 900 && n < 3; c++) begin
      @(negedge clock);
      if ((use_cpu ? cpu_tick : periph_tick) === 1'b1) begin
        n++;
        p = c - last;
        last = c;
      end
    end
    if (n < 3) begin
      fails++;
      close_out();
    end
  endtask : measure

  function automatic int exp_div(input logic [2:0] s, input logic [2:0] c);
    if (s != CCRD_OSC_FAST && s != CCRD_OSC_SLOW) return 1;
    return (c == 3'h7) ? 256 : (1 << c);
  endfunction : exp_div

  initial begin
    {clk_en, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {fast_rc_tick, slow_rc_tick, osc_tick, irq_in} = '0;
    current_osc_select = CCRD_OSC_FAST;
    fails = 0;
    tests_run = 0;
    seed = 32'hebfe;
    resetn = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    clk_en <= 1'b1;
    rd(4'h0, word);
    check(word, 16'h3100);
    rd(4'h5, word);
    check(word, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      word = 16'($random(seed));
      wr(4'h0, word);
      rd(4'h0, got);
      check(got, word & 16'hFF00);
    end
    @(posedge clock);
    clk_en <= 1'b0;
    wr(4'h0, ~got);
    clk_en <= 1'b1;
    rd(4'h0, word);
    check(word, got);
    $display("test register access done");
    for (int s = 5; s < 8; s++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge clock);
        current_osc_select <= 3'(s);
        fast_rc_tick <= (s == 7);
        slow_rc_tick <= (s == 6);
        osc_tick     <= (s < 6);
        wr(4'h0, {5'h00, 3'(c), 8'hA5});
        measure(1'b0, per);
        check(16'(per), 16'(exp_div(3'(s), 3'(c))));
      end
    end
    $display("test postscaler done");
    @(posedge clock);
    current_osc_select <= CCRD_OSC_FAST;
    fast_rc_tick <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      wr(4'h0, {1'b0, 3'(f), 1'b1, 3'h0, 8'h00});
      measure(1'b1, per);
      check(16'(per), 16'(1 << f));
      check(16'(ratio_active), 16'(f != 0));
    end
    wr(4'h0, 16'h7000);
    measure(1'b1, per);
    check(16'(per), 16'h0001);
    $display("test ratio done");
    wr(4'h0, 16'hB900);
    @(posedge clock);
    irq_in <= 1'b1;
    @(posedge clock);
    irq_in <= 1'b0;
    rd(4'h0, word);
    check(word, 16'hB100);
    measure(1'b1, per);
    // Ratio back to 1:1, so CPU follows the postscale-001 periph tick
    check(16'(per), 16'(exp_div(CCRD_OSC_FAST, 3'h1)));
    wr(4'h0, 16'h3900);
    @(posedge clock);
    irq_in <= 1'b1;
    @(posedge clock);
    irq_in <= 1'b0;
    rd(4'h0, word);
    check(word, 16'h3900);
    $display("test interrupt recovery done");
    close_out();
  end
endmodule : ccrd_top_test
